/* File: irq_bit.sv */
`timescale 1ns/1ns
module irq_bit (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic en_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      flag_o
);
   // Set wins over clear so no event is lost
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_o <= 1'b0;
      end else if (en_i) begin
         if (set_i) begin
            flag_o <= 1'b1;
         end else if (clr_i) begin
            flag_o <= 1'b0;
         end
      end
   end
endmodule

/* File: serial_ctrl.sv */
`timescale 1ns/1ns
module serial_ctrl
   import serial_ctrl_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic [31:0] addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   input  wire logic        parity_err_i,
   input  wire logic        framing_err_i,
   input  wire logic        tx_dma_b_done_i,
   input  wire logic        tx_dma_a_done_i,
   input  wire logic        rx_dma_b_done_i,
   input  wire logic        rx_dma_a_done_i,
   input  wire logic        tx_underrun_i,
   input  wire logic        rx_overrun_i,
   input  wire logic        tx_idle_i,
   input  wire logic        tx_space_i,
   input  wire logic        rx_has_data_i,
   input  wire logic        cts_n_i,
   input  wire logic        rts_n_req_i,
   output logic             rts_n_o,
   output logic             rts_oe_o,
   input  wire logic        spi_sclk_i,
   input  wire logic        spi_ssel_n_i,
   output logic             spi_sclk_rise_o,
   output logic             spi_selected_o,
   output logic             cts_ok_o,
   output logic [1:0]       mode_o,
   output logic             irq_o
);

   // ---------------------------------------------------------------
   // Registers and decode
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF  = 3'b001,
      ST_UART = 3'b010,
      ST_SPI  = 3'b100
   } mode_state_t;

   mode_state_t          state_q;
   logic [1:0]           mode_q;
   logic [NUM_SRC-1:0]   enable_q;
   logic                 trigger_edge_q;
   logic                 flow_ctrl_q;
   logic [NUM_SRC-1:0]   pending;
   logic [NUM_SRC-1:0]   events;
   logic [NUM_SRC-1:0]   clear;
   logic                 wr_pend;
   logic                 wr_en;
   logic                 wr_mode;
   logic                 wr_trig;
   logic                 wr_flow;
   logic                 level_req;
   logic                 level_req_q;
   logic [2:0]           pin_sync;
   logic                 sclk_prev_q;
   logic                 uart_on;
   logic                 spi_on;

   assign wr_pend = wr_i && (addr_i == PENDING_ADDR);
   assign wr_en   = wr_i && (addr_i == ENABLE_ADDR);
   assign wr_mode = wr_i && (addr_i == MODE_ADDR);
   assign wr_trig = wr_i && (addr_i == TRIGGER_ADDR);
   assign wr_flow = wr_i && (addr_i == FLOW_ADDR);
   assign uart_on = (state_q == ST_UART);
   assign spi_on  = (state_q == ST_SPI);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q  <= MODE_OFF;
         state_q <= ST_OFF;
      end else if (ce_i && wr_mode) begin
         mode_q <= wdata_i[1:0];
         case (wdata_i[1:0])
            MODE_UART: begin
               state_q <= ST_UART;
            end
            MODE_SPI: begin
               state_q <= ST_SPI;
            end
            default: begin
               state_q <= ST_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_q <= RESET_WORD[NUM_SRC-1:0];
      end else if (ce_i && wr_en) begin
         enable_q <= wdata_i[NUM_SRC-1:0] & SRC_VALID;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trigger_edge_q <= 1'b0;
         flow_ctrl_q    <= 1'b0;
      end else if (ce_i) begin
         if (wr_trig) begin
            trigger_edge_q <= wdata_i[0];
         end
         if (wr_flow) begin
            flow_ctrl_q <= wdata_i[0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Pending flags
   // ---------------------------------------------------------------
   // UART errors only count while UART mode is selected
   always_comb begin
      events               = '0;
      events[BIT_PARITY]   = parity_err_i && uart_on;
      events[BIT_FRAMING]  = framing_err_i && uart_on;
      events[BIT_TXDMA_B]  = tx_dma_b_done_i;
      events[BIT_TXDMA_A]  = tx_dma_a_done_i;
      events[BIT_RXDMA_B]  = rx_dma_b_done_i;
      events[BIT_RXDMA_A]  = rx_dma_a_done_i;
      events[BIT_UNDERRUN] = tx_underrun_i;
      events[BIT_OVERRUN]  = rx_overrun_i;
      events[BIT_IDLE]     = tx_idle_i;
      events[BIT_SPACE]    = tx_space_i;
      events[BIT_RXDATA]   = rx_has_data_i;
   end

   assign clear = wr_pend ? wdata_i[NUM_SRC-1:0] : '0;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
         if (SRC_VALID[gi]) begin : g_on
            irq_bit u_bit (
               .clk_i  (clk_i),
               .rst_i  (rst_i),
               .en_i   (ce_i),
               .set_i  (events[gi]),
               .clr_i  (clear[gi]),
               .flag_o (pending[gi])
            );
         end else begin : g_off
            assign pending[gi] = 1'b0;
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Interrupt output
   // ---------------------------------------------------------------
   // Edge style gives a one-cycle pulse on each rise of the request
   assign level_req = |(pending & enable_q);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_req_q <= 1'b0;
         irq_o       <= 1'b0;
      end else if (ce_i) begin
         level_req_q <= level_req;
         irq_o       <= trigger_edge_q ? (level_req && !level_req_q) : level_req;
      end
   end

   // ---------------------------------------------------------------
   // Pins
   // ---------------------------------------------------------------
   sync2 #(.W(3)) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .en_i  (ce_i),
      .d_i   ({cts_n_i, spi_sclk_i, spi_ssel_n_i}),
      .q_o   (pin_sync)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rts_n_o         <= 1'b1;
         rts_oe_o        <= 1'b0;
         cts_ok_o        <= 1'b0;
         sclk_prev_q     <= 1'b0;
         spi_sclk_rise_o <= 1'b0;
         spi_selected_o  <= 1'b0;
         mode_o          <= MODE_OFF;
         rdata_o         <= RESET_WORD;
      end else if (ce_i) begin
         rts_oe_o        <= uart_on && flow_ctrl_q;
         rts_n_o         <= !(uart_on && flow_ctrl_q) || rts_n_req_i;
         cts_ok_o        <= uart_on && (!flow_ctrl_q || !pin_sync[2]);
         sclk_prev_q     <= pin_sync[1];
         spi_sclk_rise_o <= spi_on && pin_sync[1] && !sclk_prev_q;
         spi_selected_o  <= spi_on && !pin_sync[0];
         mode_o          <= mode_q;
         rdata_o         <= RESET_WORD;
         if (rd_i) begin
            case (addr_i)
               PENDING_ADDR: begin
                  rdata_o <= {17'h00000, pending};
               end
               ENABLE_ADDR: begin
                  rdata_o <= {17'h00000, enable_q};
               end
               TRIGGER_ADDR: begin
                  rdata_o <= {31'h00000000, trigger_edge_q};
               end
               MODE_ADDR: begin
                  rdata_o <= {30'h00000000, mode_q};
               end
               FLOW_ADDR: begin
                  rdata_o <= {31'h00000000, flow_ctrl_q};
               end
               default: begin
                  rdata_o <= RESET_WORD;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Flags and outputs are registered, so effects are checked one cycle on
   mode_reset_a: assert property (@(posedge clk_i) $past(rst_i) |-> mode_o == MODE_OFF)
      else $error("mode not disabled after reset");
   enable_reset_a: assert property (@(posedge clk_i) $past(rst_i) |-> enable_q == '0)
      else $error("enable not zero after reset");
   mode_uart_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr_mode && wdata_i[1:0] == MODE_UART |=> uart_on)
      else $error("uart mode not selected");
   mode_spi_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr_mode && wdata_i[1:0] == MODE_SPI |=> spi_on)
      else $error("spi mode not selected");
   mode_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr_mode && wdata_i[1:0] != MODE_UART && wdata_i[1:0] != MODE_SPI |=> state_q == ST_OFF)
      else $error("unused mode not disabled");
   mode_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr_mode |=> mode_q == $past(wdata_i[1:0]))
      else $error("mode field not stored");
   enable_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr_en |=> enable_q == ($past(wdata_i[NUM_SRC-1:0]) & SRC_VALID))
      else $error("enable write not stored");
   parity_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && parity_err_i && uart_on |=> pending[BIT_PARITY])
      else $error("parity error not flagged");
   framing_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && framing_err_i && uart_on |=> pending[BIT_FRAMING])
      else $error("framing error not flagged");
   uart_parity_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !uart_on && !pending[BIT_PARITY] |=> !pending[BIT_PARITY])
      else $error("parity flagged outside uart mode");
   uart_framing_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !uart_on && !pending[BIT_FRAMING] |=> !pending[BIT_FRAMING])
      else $error("framing flagged outside uart mode");
   txb_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && tx_dma_b_done_i |=> pending[BIT_TXDMA_B])
      else $error("tx buffer b not flagged");
   txa_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && tx_dma_a_done_i |=> pending[BIT_TXDMA_A])
      else $error("tx buffer a not flagged");
   rxb_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && rx_dma_b_done_i |=> pending[BIT_RXDMA_B])
      else $error("rx buffer b not flagged");
   rxa_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && rx_dma_a_done_i |=> pending[BIT_RXDMA_A])
      else $error("rx buffer a not flagged");
   event_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && tx_underrun_i |=> pending[BIT_UNDERRUN])
      else $error("underrun not flagged");
   overrun_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && rx_overrun_i |=> pending[BIT_OVERRUN])
      else $error("overrun not flagged");
   idle_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && tx_idle_i |=> pending[BIT_IDLE])
      else $error("idle not flagged");
   space_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && tx_space_i |=> pending[BIT_SPACE])
      else $error("tx space not flagged");
   rxdata_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && rx_has_data_i |=> pending[BIT_RXDATA])
      else $error("rx data not flagged");
   zero_keeps_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr_pend && !wdata_i[BIT_OVERRUN] && pending[BIT_OVERRUN] |=> pending[BIT_OVERRUN])
      else $error("write zero cleared flag");
   one_clears_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr_pend && wdata_i[BIT_IDLE] && !tx_idle_i |=> !pending[BIT_IDLE])
      else $error("write one did not clear");
   level_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !trigger_edge_q |=> irq_o == $past(level_req))
      else $error("level irq mismatch");
   // A switch from level to edge style may still show one level cycle
   edge_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(ce_i) && $past(ce_i, 2) && $past(trigger_edge_q) && irq_o |-> !$past(irq_o))
      else $error("edge irq longer than a pulse");
   edge_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && trigger_edge_q && level_req && !level_req_q |=> irq_o)
      else $error("edge irq pulse missing");
   rts_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rts_oe_o && $past(ce_i) |-> $past(uart_on && flow_ctrl_q))
      else $error("rts driven without flow control");
   rts_idle_a: assert property (@(posedge clk_i) disable iff (rst_i) !rts_oe_o |-> rts_n_o)
      else $error("rts low while not driven");
   spi_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
      spi_selected_o && $past(ce_i) |-> $past(spi_on))
      else $error("select seen outside spi mode");
   // Stale read data would look like a second answer
   read_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(ce_i) && !$past(rd_i) |-> rdata_o == RESET_WORD)
      else $error("read data outside read cycle");
   hold_state_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !ce_i |=> pending == $past(pending) && enable_q == $past(enable_q) && mode_q == $past(mode_q))
      else $error("state moved while enable low");
endmodule

/* File: serial_ctrl_pkg.sv */
// Summary of operation
// - A setting makes the controller interrupt either edge or level triggered.
// - Two-bit mode: 0 disabled, 1 UART, 2 SPI; resets to disabled.
// - In UART mode request-to-send drives only with flow control; clear-to-send is input.
// - UART parity error sets pending bit 14, framing error sets bit 13.
// - Transmit DMA buffer B unloaded sets bit 12, buffer A sets bit 11.
// - Receive DMA buffer B complete sets bit 10, buffer A sets bit 9.
// - Transmit underrun sets pending bit 4.
// - Receive overrun sets pending bit 3.
// - Transmitter idle sets pending bit 2.
// - Transmit buffer with free room sets pending bit 1.
// - Receive buffer holding unread data sets pending bit 0.
// - Enable register mirrors pending layout; resets to zero.
// - SPI mode is slave only; clock and select are inputs.
package serial_ctrl_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [31:0] PENDING_ADDR = 32'h4000a808;
   localparam logic [31:0] ENABLE_ADDR  = 32'h4000a848;
   localparam logic [31:0] TRIGGER_ADDR = 32'h4000a84c;
   localparam logic [31:0] MODE_ADDR    = 32'h4000c854;
   localparam logic [31:0] FLOW_ADDR    = 32'h4000c858;
   localparam logic [31:0] RESET_WORD   = 32'h00000000;

   // ---------------------------------------------------------------
   // Fields
   // ---------------------------------------------------------------
   localparam int          NUM_SRC      = 15;
   localparam logic [14:0] SRC_VALID    = 15'h7e1f;
   localparam logic [1:0]  MODE_OFF     = 2'h0;
   localparam logic [1:0]  MODE_UART    = 2'h1;
   localparam logic [1:0]  MODE_SPI     = 2'h2;
   localparam int          BIT_PARITY   = 14;
   localparam int          BIT_FRAMING  = 13;
   localparam int          BIT_TXDMA_B  = 12;
   localparam int          BIT_TXDMA_A  = 11;
   localparam int          BIT_RXDMA_B  = 10;
   localparam int          BIT_RXDMA_A  = 9;
   localparam int          BIT_UNDERRUN = 4;
   localparam int          BIT_OVERRUN  = 3;
   localparam int          BIT_IDLE     = 2;
   localparam int          BIT_SPACE    = 1;
   localparam int          BIT_RXDATA   = 0;

endpackage

/* File: spi_uart_peer.sv */
`timescale 1ns/1ns
module spi_uart_peer (
   output logic cts_n_o,
   output logic sclk_o,
   output logic ssel_n_o
);
   // ---------------------------------------------
   // Far-side master and peer
   // ---------------------------------------------
   // Clock idles low outside frames, never free running
   initial begin
      cts_n_o  = 1'b1;
      sclk_o   = 1'b0;
      ssel_n_o = 1'b1;
   end

   task automatic set_cts(input logic ready_n);
      cts_n_o = ready_n;
   endtask

   task automatic frame(input int edges);
      ssel_n_o = 1'b0;
      #100;
      for (int i = 0; i < edges; i++) begin
         #62 sclk_o = 1'b1;
         #63 sclk_o = 1'b0;
      end
      #100 ssel_n_o = 1'b1;
   endtask
endmodule

/* File: sync2.sv */
`timescale 1ns/1ns
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         en_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= '0;
         q_o    <= '0;
      end else if (en_i) begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   import serial_ctrl_pkg::*;
   logic        clk_i, rst_i, ce_i, wr_i, rd_i, rts_n_req_i;
   logic [31:0] addr_i, wdata_i, rdata_o;
   logic [14:0] evt;
   logic        cts_n, sclk, ssel_n, rts_n_o, rts_oe_o, rise_o, sel_o, cts_ok_o, irq_o;
   logic [1:0]  mode_o;
   int          err_total, compares, rises, r0;
   int          bits [11] = '{14, 13, 12, 11, 10, 9, 4, 3, 2, 1, 0};

   // ---------------------------------------------
   // Design and far side
   // ---------------------------------------------
   serial_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .parity_err_i(evt[BIT_PARITY]),
      .framing_err_i(evt[BIT_FRAMING]), .tx_dma_b_done_i(evt[BIT_TXDMA_B]),
      .tx_dma_a_done_i(evt[BIT_TXDMA_A]), .rx_dma_b_done_i(evt[BIT_RXDMA_B]),
      .rx_dma_a_done_i(evt[BIT_RXDMA_A]), .tx_underrun_i(evt[BIT_UNDERRUN]),
      .rx_overrun_i(evt[BIT_OVERRUN]), .tx_idle_i(evt[BIT_IDLE]), .tx_space_i(evt[BIT_SPACE]),
      .rx_has_data_i(evt[BIT_RXDATA]), .cts_n_i(cts_n), .rts_n_req_i(rts_n_req_i),
      .rts_n_o(rts_n_o), .rts_oe_o(rts_oe_o), .spi_sclk_i(sclk), .spi_ssel_n_i(ssel_n),
      .spi_sclk_rise_o(rise_o), .spi_selected_o(sel_o), .cts_ok_o(cts_ok_o), .mode_o(mode_o),
      .irq_o(irq_o));
   spi_uart_peer peer_u (.cts_n_o(cts_n), .sclk_o(sclk), .ssel_n_o(ssel_n));

   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic report_and_stop();
      if (err_total == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // Read data only stand in the cycle after the strobe
   task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, exp);
   endtask
   task automatic pulse(input int b);
      @(posedge clk_i);
      evt[b] <= 1'b1;
      @(posedge clk_i);
      evt[b] <= 1'b0;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // ---------------------------------------------
   // Clock, watchdog, sequence
   // ---------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (rise_o === 1'b1) rises <= rises + 1;
   end
   initial begin
      #200000;
      err_total++;
      report_and_stop();
   end
   initial begin
      rst_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; addr_i = '0; wdata_i = '0;
      evt = '0; rts_n_req_i = 1'b1; err_total = 0; compares = 0; rises = 0;
      ce_i = 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(PENDING_ADDR, RESET_WORD);
      rchk(ENABLE_ADDR, RESET_WORD);
      rchk(MODE_ADDR, RESET_WORD);
      rchk(32'h4000a900, 32'h00000000);
      wr(MODE_ADDR, 32'h00000002);
      rchk(MODE_ADDR, 32'h00000002);
      chk({30'h0, mode_o}, {30'h0, MODE_SPI});
      r0 = rises;
      fork
         peer_u.frame(8);
         begin
            tick(30);
            chk({31'h0, sel_o}, 32'h1);
         end
      join
      tick(20);
      chk(rises - r0, 32'h8);
      chk({31'h0, sel_o}, 32'h0);
      // Parity only counts while the UART is running
      wr(MODE_ADDR, 32'h00000000);
      pulse(BIT_PARITY);
      rchk(PENDING_ADDR, 32'h00000000);
      // Settings first, mode last
      wr(FLOW_ADDR, 32'h00000000);
      wr(TRIGGER_ADDR, 32'h00000000);
      wr(ENABLE_ADDR, 32'hffffffff);
      wr(MODE_ADDR, 32'h00000001);
      rchk(ENABLE_ADDR, {17'h0, SRC_VALID});
      foreach (bits[i]) begin
         pulse(bits[i]);
         rchk(PENDING_ADDR, 32'h1 << bits[i]);
         chk({31'h0, irq_o}, 32'h1);
         wr(PENDING_ADDR, 32'h00000000);
         rchk(PENDING_ADDR, 32'h1 << bits[i]);
         wr(PENDING_ADDR, 32'h1 << bits[i]);
         rchk(PENDING_ADDR, 32'h00000000);
         chk({31'h0, irq_o}, 32'h0);
      end
      wr(ENABLE_ADDR, 32'h1 << BIT_OVERRUN);
      pulse(BIT_RXDATA);
      tick(2);
      chk({31'h0, irq_o}, 32'h0);
      rchk(PENDING_ADDR, 32'h00000001);
      pulse(BIT_OVERRUN);
      tick(2);
      chk({31'h0, irq_o}, 32'h1);
      wr(PENDING_ADDR, 32'h00000009);
      tick(2);
      chk({31'h0, irq_o}, 32'h0);
      // Edge style gives one pulse, not a level
      wr(TRIGGER_ADDR, 32'h00000001);
      pulse(BIT_OVERRUN);
      tick(1);
      chk({31'h0, irq_o}, 32'h1);
      tick(1);
      chk({31'h0, irq_o}, 32'h0);
      tick(2);
      chk({31'h0, rts_oe_o}, 32'h0);
      wr(FLOW_ADDR, 32'h00000001);
      @(posedge clk_i);
      rts_n_req_i <= 1'b0;
      tick(3);
      chk({30'h0, rts_oe_o, rts_n_o}, 32'h2);
      peer_u.set_cts(1'b1);
      tick(5);
      chk({31'h0, cts_ok_o}, 32'h0);
      peer_u.set_cts(1'b0);
      tick(5);
      chk({31'h0, cts_ok_o}, 32'h1);
      // Clock enable low freezes flags and registers
      @(posedge clk_i);
      ce_i <= 1'b0;
      pulse(BIT_TXDMA_A);
      wr(MODE_ADDR, 32'h00000002);
      @(posedge clk_i);
      ce_i <= 1'b1;
      rchk(MODE_ADDR, 32'h00000001);
      rchk(PENDING_ADDR, 32'h00000008);
      // Unused mode code reads back but acts as disabled
      wr(MODE_ADDR, 32'h00000003);
      rchk(MODE_ADDR, 32'h00000003);
      chk({29'h0, rts_oe_o, rts_n_o, cts_ok_o}, 32'h2);
      // Reset in mid-run clears enables, flags and mode
      @(posedge clk_i);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(ENABLE_ADDR, RESET_WORD);
      rchk(PENDING_ADDR, RESET_WORD);
      chk({30'h0, mode_o}, {30'h0, MODE_OFF});
      report_and_stop();
   end
endmodule
